// >>> core/flash_wp_pkg.sv
// constants and carrier types for the flash write-protection block
package flash_wp_pkg;
   // instruction opcodes
   localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
   localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
   localparam logic [7:0] OP_FUNC_WRITE     = 8'h42;
   localparam logic [7:0] OP_CHIP_ERASE_A   = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_B   = 8'h60;
   localparam logic [7:0] OP_RDPARAM_V_ALT  = 8'hC0;
   localparam logic [7:0] OP_RDPARAM_V      = 8'h63;
   localparam logic [7:0] OP_BANK_V_ALT     = 8'h17;
   localparam logic [7:0] OP_BANK_V         = 8'hC5;
   localparam logic [7:0] OP_SUSPEND        = 8'h75;
   localparam logic [7:0] OP_RESUME         = 8'h7A;

   // status register field positions
   localparam int SR_BP_LSB = 2;
   localparam int SR_QE     = 6;
   localparam int SR_STATUS_WRITE_DISABLE   = 7;
   localparam int SR_WEL    = 1;
   localparam logic [7:0] SR_WRITABLE_MASK = 8'hFC;

   // function register field positions
   localparam int FR_RST_DIS  = 0;
   localparam int FR_TBS      = 1;
   localparam int FR_PROGRAM_SUSPENDED_FLAG     = 2;
   localparam int FR_ERASE_SUSPENDED_FLAG     = 3;
   localparam int FR_IRL_LSB  = 4;
   localparam logic [7:0] FR_OTP_MASK = 8'hF3;

   // reset values
   localparam logic [7:0] SR_RESET = 8'h00;
   localparam logic [7:0] FR_RESET = 8'h00;

   // layout sizes
   localparam int BLK_W = 12;
   localparam logic [12:0] BLOCKS_4K   = 13'h1000;
   localparam logic [12:0] BLOCKS_1K   = 13'h0400;
   localparam logic [12:0] PROT_CODE13 = 13'h0C00;
   localparam logic [12:0] PROT_CODE14 = 13'h0E00;
   localparam logic [3:0]  CODE_ALL_1K = 4'hB;

   typedef enum logic [2:0] {
      OP_IDLE     = 3'b001,
      OP_PROGRAM  = 3'b010,
      OP_ERASE    = 3'b100
   } op_kind_e;

   // one instruction presented by the serial engine
   typedef struct packed {
      logic                 valid;
      logic [7:0]           opcode;
      logic                 is_program;
      logic                 is_erase;
      logic [BLK_W-1:0]     block;
      logic [7:0]           data;
   } instr_s;

   // decisions handed back to the serial engine
   typedef struct packed {
      logic                 go;
      logic                 inhibited;
      logic                 program_start;
      logic                 erase_start;
   } verdict_s;
endpackage

// >>> core/flash_write_protection.sv
// write-protect decode, status/function register guard and quad pin steering
`timescale 1ns/1ps
module flash_write_protection (
   input  wire logic                 clk,            // serial-side clock
   input  wire logic                 rst_b,          // power-up load, active low
   input  wire logic                 layout_1k,      // 1024-block option strap
   input  wire logic                 rst_dis_default,// package default of reset-disable bit
   input  wire flash_wp_pkg::instr_s instr,          // decoded instruction
   input  wire logic                 op_done,        // program or erase finished
   input  wire logic                 wp_pin_b,       // write-protect pin level
   input  wire logic                 hold_pin_b,     // hold/reset pin level
   output logic [7:0]                status_q,       // status register
   output logic [7:0]                func_q,         // function register
   output flash_wp_pkg::verdict_s    verdict_q,      // per-instruction decision
   output logic                      quad_lines_q,   // pins act as data lines 2/3
   output logic                      wp_active_q,    // high while quad is off; status lock reads the pin in both modes
   output logic                      hold_active_b_q // hold/reset asserted, active low
);
   flash_wp_pkg::op_kind_e op_q;
   logic                    init_q;
   logic [7:0]              status_d;
   logic [7:0]              func_d;

   // protected count for a code in either layout
   function automatic logic [12:0] prot_count(input logic [3:0] code, input logic one_k);
      logic [12:0] n;
      n = 13'h0000;
      if (code == 4'h0) begin
         n = 13'h0000;
      end else if (one_k) begin
         if (code >= flash_wp_pkg::CODE_ALL_1K) begin
            n = flash_wp_pkg::BLOCKS_1K;
         end else begin
            n = 13'(13'h0001 << (code - 4'h1));
         end
      end else begin
         case (code)
            4'hD:    n = flash_wp_pkg::PROT_CODE13;
            4'hE:    n = flash_wp_pkg::PROT_CODE14;
            4'hF:    n = flash_wp_pkg::BLOCKS_4K;
            default: n = 13'(13'h0001 << (code - 4'h1));
         endcase
      end
      return n;
   endfunction

   wire logic [3:0]  bp_code    = status_q[flash_wp_pkg::SR_BP_LSB +: 4];
   wire logic        write_enable_latch        = status_q[flash_wp_pkg::SR_WEL];
   wire logic        top_bottom_select        = func_q[flash_wp_pkg::FR_TBS];
   wire logic [12:0] total      = layout_1k ? flash_wp_pkg::BLOCKS_1K : flash_wp_pkg::BLOCKS_4K;
   wire logic [12:0] count      = prot_count(bp_code, layout_1k);
   wire logic [12:0] blk        = {1'b0, instr.block};
   wire logic [12:0] boundary   = 13'(total - count);
   // bottom counts up from 0, top counts down from the last block
   wire logic        in_range   = (count != 13'h0000) && (top_bottom_select ? (blk < count) : (blk >= boundary));
   wire logic        is_chip    = instr.opcode == flash_wp_pkg::OP_CHIP_ERASE_A ||
                                  instr.opcode == flash_wp_pkg::OP_CHIP_ERASE_B;
   wire logic        no_write_enable_cmd    = instr.opcode == flash_wp_pkg::OP_RDPARAM_V_ALT ||
                                  instr.opcode == flash_wp_pkg::OP_BANK_V_ALT;
   wire logic        needs_write_enable_cmd = !no_write_enable_cmd && (instr.is_program || instr.is_erase || is_chip ||
                                  instr.opcode == flash_wp_pkg::OP_STATUS_WRITE ||
                                  instr.opcode == flash_wp_pkg::OP_FUNC_WRITE ||
                                  instr.opcode == flash_wp_pkg::OP_RDPARAM_V ||
                                  instr.opcode == flash_wp_pkg::OP_BANK_V);
   // hardware lock of the status register
   wire logic        sr_locked  = status_q[flash_wp_pkg::SR_STATUS_WRITE_DISABLE] && !wp_pin_b;
   wire logic        quad       = status_q[flash_wp_pkg::SR_QE];
   wire logic        blocked    = (needs_write_enable_cmd && !write_enable_latch)
                                | ((instr.is_program || instr.is_erase) && in_range)
                                | (is_chip && bp_code != 4'h0)
                                | (instr.opcode == flash_wp_pkg::OP_STATUS_WRITE && sr_locked)
                                | (op_q != flash_wp_pkg::OP_IDLE && instr.opcode != flash_wp_pkg::OP_SUSPEND &&
                                   instr.opcode != flash_wp_pkg::OP_RESUME);
   wire logic        accept     = instr.valid && !blocked;
   wire logic        sr_write   = accept && instr.opcode == flash_wp_pkg::OP_STATUS_WRITE;
   wire logic        fr_write   = accept && instr.opcode == flash_wp_pkg::OP_FUNC_WRITE;
   wire logic        write_enable_cmd_hit   = instr.valid && instr.opcode == flash_wp_pkg::OP_WRITE_ENABLE;
   wire logic        wrdi_hit   = instr.valid && instr.opcode == flash_wp_pkg::OP_WRITE_DISABLE;
   wire logic        start_prog = accept && instr.is_program;
   wire logic        start_ers  = accept && (instr.is_erase || is_chip);
   wire logic        suspend    = instr.valid && instr.opcode == flash_wp_pkg::OP_SUSPEND &&
                                  op_q != flash_wp_pkg::OP_IDLE;
   wire logic        resume     = instr.valid && instr.opcode == flash_wp_pkg::OP_RESUME;
   wire logic        program_suspended_flag       = func_q[flash_wp_pkg::FR_PROGRAM_SUSPENDED_FLAG];
   wire logic        erase_suspended_flag       = func_q[flash_wp_pkg::FR_ERASE_SUSPENDED_FLAG];

   always_comb begin
      status_d = status_q;
      if (sr_write) begin
         status_d = (instr.data & flash_wp_pkg::SR_WRITABLE_MASK) |
                    (status_q & ~flash_wp_pkg::SR_WRITABLE_MASK);
      end
      if (write_enable_cmd_hit) begin
         status_d[flash_wp_pkg::SR_WEL] = 1'b1;
      end else if (wrdi_hit || start_prog || start_ers || sr_write || fr_write) begin
         status_d[flash_wp_pkg::SR_WEL] = 1'b0; // latch cleared by write disable or consumed by the write
      end
   end

   always_comb begin
      func_d = func_q;
      if (fr_write) begin
         // one-time bits only ever gain ones
         func_d = func_q | (instr.data & flash_wp_pkg::FR_OTP_MASK);
      end
      // set wins over clear within the same cycle
      if (resume && program_suspended_flag) begin
         func_d[flash_wp_pkg::FR_PROGRAM_SUSPENDED_FLAG] = 1'b0;
      end else if (resume && erase_suspended_flag) begin
         func_d[flash_wp_pkg::FR_ERASE_SUSPENDED_FLAG] = 1'b0;
      end
      if (suspend && op_q == flash_wp_pkg::OP_PROGRAM) begin
         func_d[flash_wp_pkg::FR_PROGRAM_SUSPENDED_FLAG] = 1'b1;
      end
      if (suspend && op_q == flash_wp_pkg::OP_ERASE) begin
         func_d[flash_wp_pkg::FR_ERASE_SUSPENDED_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_q <= flash_wp_pkg::SR_RESET;
         func_q   <= flash_wp_pkg::FR_RESET;
         init_q   <= 1'b0;
      end else begin
         status_q <= status_d;
         init_q   <= 1'b1;
         // package default captured after release, not under reset
         func_q   <= init_q ? func_d : (func_d | {7'h00, rst_dis_default});
      end
   end

   // one operation in flight; suspend parks it, resume picks it back up
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         op_q <= flash_wp_pkg::OP_IDLE;
      end else begin
         case (op_q)
            flash_wp_pkg::OP_IDLE: begin
               if (resume && (program_suspended_flag || erase_suspended_flag)) begin
                  op_q <= program_suspended_flag ? flash_wp_pkg::OP_PROGRAM : flash_wp_pkg::OP_ERASE;
               end else if (start_prog) begin
                  op_q <= flash_wp_pkg::OP_PROGRAM;
               end else if (start_ers) begin
                  op_q <= flash_wp_pkg::OP_ERASE;
               end
            end
            flash_wp_pkg::OP_PROGRAM,
            flash_wp_pkg::OP_ERASE: begin
               if (suspend || op_done) begin
                  op_q <= flash_wp_pkg::OP_IDLE;
               end
            end
            default: op_q <= flash_wp_pkg::OP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         verdict_q       <= '0;
         quad_lines_q    <= 1'b0;
         wp_active_q     <= 1'b1;
         hold_active_b_q <= 1'b1;
      end else begin
         verdict_q.go            <= accept;
         verdict_q.inhibited     <= instr.valid && blocked;
         verdict_q.program_start <= start_prog;
         verdict_q.erase_start   <= start_ers;
         // pins become data lines when quad is on; host keeps quad off if strapped
         quad_lines_q            <= quad;
         wp_active_q             <= !quad;
         hold_active_b_q         <= quad ? 1'b1 : hold_pin_b;
      end
   end

   chk_chip_erase_guard: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && is_chip && bp_code != 4'h0) |=> !verdict_q.go && verdict_q.inhibited)
      else $error("chip erase accepted with protect bits set");
   chk_range_inhibit: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && (instr.is_program || instr.is_erase) && in_range) |=> !verdict_q.program_start &&
      !verdict_q.erase_start)
      else $error("write into protected range started");
   chk_status_lock: assert property (@(posedge clk) disable iff (!rst_b)
      (sr_locked && !write_enable_cmd_hit && !wrdi_hit && op_q == flash_wp_pkg::OP_IDLE) |=>
      status_q[7:2] == $past(status_q[7:2]))
      else $error("locked status bits changed");
   chk_status_write: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.opcode == flash_wp_pkg::OP_STATUS_WRITE && !sr_locked && write_enable_latch &&
      op_q == flash_wp_pkg::OP_IDLE) |=> status_q[7:2] == $past(instr.data[7:2]))
      else $error("status write not applied");
   chk_otp_sticky: assert property (@(posedge clk) disable iff (!rst_b)
      ((func_q & flash_wp_pkg::FR_OTP_MASK) != 8'h00) |=>
      ((func_q & $past(func_q) & flash_wp_pkg::FR_OTP_MASK) == ($past(func_q) & flash_wp_pkg::FR_OTP_MASK)))
      else $error("one-time bit cleared");
   chk_prog_suspend: assert property (@(posedge clk) disable iff (!rst_b)
      (suspend && op_q == flash_wp_pkg::OP_PROGRAM) |=> program_suspended_flag && op_q == flash_wp_pkg::OP_IDLE)
      else $error("program suspend flag not set");
   chk_erase_suspend: assert property (@(posedge clk) disable iff (!rst_b)
      (suspend && op_q == flash_wp_pkg::OP_ERASE) |=> erase_suspended_flag && op_q == flash_wp_pkg::OP_IDLE)
      else $error("erase suspend flag not set");
   chk_wel_needed: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && needs_write_enable_cmd && !write_enable_latch) |=> !verdict_q.go)
      else $error("write accepted without enable latch");
   chk_alt_no_write_enable_cmd: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && no_write_enable_cmd && op_q == flash_wp_pkg::OP_IDLE) |=> verdict_q.go)
      else $error("alternate volatile write refused");
   chk_quad_pins: assert property (@(posedge clk) disable iff (!rst_b)
      quad |=> quad_lines_q && !wp_active_q)
      else $error("quad pins not repurposed");
   chk_top_range: assert property (@(posedge clk) disable iff (!rst_b)
      (!top_bottom_select && bp_code == 4'h1 && !layout_1k) |-> (in_range == (instr.block == 12'hFFF)))
      else $error("top range decode wrong");

   // enable latch: set by its own command, cleared by write disable, spent by an accepted program, erase, status or function write
   chk_wel_set: assert property (@(posedge clk) disable iff (!rst_b)
      write_enable_cmd_hit |=> write_enable_latch)
      else $error("enable latch not set");

   chk_wel_clear: assert property (@(posedge clk) disable iff (!rst_b)
      wrdi_hit |=> !write_enable_latch)
      else $error("enable latch not cleared by disable");

   chk_wel_op_spent: assert property (@(posedge clk) disable iff (!rst_b)
      ((start_prog || start_ers) && !write_enable_cmd_hit) |=> !write_enable_latch)
      else $error("enable latch kept after operation start");

   chk_wel_reg_spent: assert property (@(posedge clk) disable iff (!rst_b)
      (sr_write || fr_write) |=> !write_enable_latch)
      else $error("enable latch kept after register write");

   // range decode corners; the index compare must match the block tables
   chk_bottom_range: assert property (@(posedge clk) disable iff (!rst_b)
      (top_bottom_select && bp_code == 4'h1 && !layout_1k) |-> (in_range == (instr.block == 12'h000)))
      else $error("bottom range decode wrong");

   chk_zero_code: assert property (@(posedge clk) disable iff (!rst_b)
      (bp_code == 4'h0) |-> !in_range)
      else $error("zero protect code protects a block");

   chk_all_4k: assert property (@(posedge clk) disable iff (!rst_b)
      (!layout_1k && bp_code == 4'hF) |-> in_range)
      else $error("full protect code leaves a block open");

   chk_code13_top: assert property (@(posedge clk) disable iff (!rst_b)
      (!layout_1k && !top_bottom_select && bp_code == 4'hD) |-> (in_range == (instr.block >= 12'h400)))
      else $error("code 13 top range wrong");

   chk_code14_bottom: assert property (@(posedge clk) disable iff (!rst_b)
      (!layout_1k && top_bottom_select && bp_code == 4'hE) |-> (in_range == (instr.block < 12'hE00)))
      else $error("code 14 bottom range wrong");

   chk_all_1k: assert property (@(posedge clk) disable iff (!rst_b)
      (layout_1k && bp_code >= 4'hB && instr.block < 12'h400) |-> in_range)
      else $error("1024-block full code leaves a block open");

   chk_1k_code10: assert property (@(posedge clk) disable iff (!rst_b)
      (layout_1k && !top_bottom_select && bp_code == 4'hA) |-> (in_range == (instr.block >= 12'h200)))
      else $error("1024-block code 10 range wrong");

   chk_chip_erase_free: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && is_chip && bp_code == 4'h0 && write_enable_latch && op_q == flash_wp_pkg::OP_IDLE) |=>
      verdict_q.erase_start)
      else $error("chip erase refused with protect bits clear");

   // suspend flags clear on resume, the program flag ahead of the erase flag, and are not host writable
   chk_prog_resume: assert property (@(posedge clk) disable iff (!rst_b)
      (resume && program_suspended_flag) |=> !program_suspended_flag)
      else $error("program suspend flag not cleared");

   chk_erase_resume: assert property (@(posedge clk) disable iff (!rst_b)
      (resume && erase_suspended_flag && !program_suspended_flag) |=> !erase_suspended_flag)
      else $error("erase suspend flag not cleared");

   chk_susp_readonly: assert property (@(posedge clk) disable iff (!rst_b)
      fr_write |=> (func_q[3:2] == $past(func_q[3:2])))
      else $error("suspend flags changed by register write");

   // status lock and pin steering
   chk_hold_pin: assert property (@(posedge clk) disable iff (!rst_b)
      !quad |=> (wp_active_q && !quad_lines_q && hold_active_b_q == $past(hold_pin_b)))
      else $error("protect and hold pin functions not live");

   chk_quad_hold: assert property (@(posedge clk) disable iff (!rst_b)
      quad |=> hold_active_b_q)
      else $error("hold asserted while pins are data lines");

   chk_lock_refuse: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.opcode == flash_wp_pkg::OP_STATUS_WRITE && sr_locked) |=>
      verdict_q.inhibited && !verdict_q.go)
      else $error("locked status write not refused");

   chk_unlock_pin_high: assert property (@(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.opcode == flash_wp_pkg::OP_STATUS_WRITE &&
      status_q[flash_wp_pkg::SR_STATUS_WRITE_DISABLE] && wp_pin_b && write_enable_latch && op_q == flash_wp_pkg::OP_IDLE &&
      !instr.is_program && !instr.is_erase) |=> verdict_q.go)
      else $error("status write refused with protect pin high");
endmodule

// >>> tb/flash_host_model.sv
// host controller model that presents one decoded instruction per request
`timescale 1ns/1ps
module flash_host_model (
   input  wire logic                 rst_b, // power-up load, active low
   input  wire logic                 send,  // request strobe from the bench
   input  wire flash_wp_pkg::instr_s cmd,   // instruction to present
   output flash_wp_pkg::instr_s      instr  // instruction toward the device
);
   // idle fields carry the inverse so a stale value never looks valid
   always_comb begin
      instr       = ~cmd;
      instr.valid = 1'b0;
      if (rst_b && send) begin
         instr = cmd;
      end
   end
endmodule

// >>> tb/flash_write_protection_tb_top.sv
// self-checking bench for the flash write-protection block
`timescale 1ns/1ps
module flash_write_protection_tb_top;
   logic                   clk = 1'b0, rst_b = 1'b0, layout_1k = 1'b0, rst_dis_default = 1'b1;
   logic                   op_done = 1'b0, wp_pin_b = 1'b1, hold_pin_b = 1'b0, send = 1'b0;
   flash_wp_pkg::instr_s   cmd = '0;
   flash_wp_pkg::instr_s   instr;
   logic [7:0]             status_q, func_q;
   flash_wp_pkg::verdict_s verdict_q, v;
   logic                   quad_lines_q, wp_active_q, hold_active_b_q;
   int                     err_total = 0, tests_run = 0, cyc = 0;
   int                     n, tot, in_blk, out_blk;

   always #25 clk = ~clk;

   flash_host_model u_flash_host_model (.rst_b(rst_b), .send(send), .cmd(cmd), .instr(instr));

   flash_write_protection u_flash_write_protection (
      .clk(clk), .rst_b(rst_b), .layout_1k(layout_1k), .rst_dis_default(rst_dis_default),
      .instr(instr), .op_done(op_done), .wp_pin_b(wp_pin_b), .hold_pin_b(hold_pin_b),
      .status_q(status_q), .func_q(func_q), .verdict_q(verdict_q), .quad_lines_q(quad_lines_q),
      .wp_active_q(wp_active_q), .hold_active_b_q(hold_active_b_q));

   task automatic test_done();
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // one instruction held for one full cycle, verdict taken at the negedge that ends it
   task automatic issue(input logic [7:0] op, input logic prog, input logic ers, input logic [11:0] blk,
                        input logic [7:0] dat);
      @(negedge clk);
      cmd  = '{valid: 1'b1, opcode: op, is_program: prog, is_erase: ers, block: blk, data: dat};
      send = 1'b1;
      @(negedge clk);
      v    = verdict_q;
      send = 1'b0;
   endtask

   task automatic finish_op();
      @(negedge clk);
      op_done = 1'b1;
      @(negedge clk);
      op_done = 1'b0;
   endtask

   task automatic set_sr(input logic [7:0] dat);
      issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
      issue(flash_wp_pkg::OP_STATUS_WRITE, 1'b0, 1'b0, 12'h000, dat);
   endtask

   function automatic int prot_count(input int code, input logic one_k);
      if (code == 0) return 0;
      if (one_k) return (code <= 10) ? (1 << (code - 1)) : 1024;
      if (code <= 12) return 1 << (code - 1);
      return (code == 13) ? 3072 : (code == 14) ? 3584 : 4096;
   endfunction

   // hang guard, well above the roughly eleven hundred cycles the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   initial begin
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk(status_q, 16'h0000);
      chk(func_q, 16'h0001);
      chk({quad_lines_q, wp_active_q, hold_active_b_q}, 16'h0002);
      issue(flash_wp_pkg::OP_RDPARAM_V_ALT, 1'b0, 1'b0, 12'h000, 8'h00);
      chk(v, 16'h0008);
      issue(flash_wp_pkg::OP_BANK_V_ALT, 1'b0, 1'b0, 12'h000, 8'h00);
      chk(v, 16'h0008);
      issue(flash_wp_pkg::OP_RDPARAM_V, 1'b0, 1'b0, 12'h000, 8'h00);
      chk(v, 16'h0004);
      issue(flash_wp_pkg::OP_STATUS_WRITE, 1'b0, 1'b0, 12'h000, 8'h3C);
      chk(status_q, 16'h0000);
      issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
      issue(flash_wp_pkg::OP_WRITE_DISABLE, 1'b0, 1'b0, 12'h000, 8'h00);
      chk(status_q[1], 16'h0000);
      issue(flash_wp_pkg::OP_STATUS_WRITE, 1'b0, 1'b0, 12'h000, 8'h3C);
      chk(v, 16'h0004);
      chk(status_q, 16'h0000);
      for (int tb = 0; tb < 2; tb++) begin
         if (tb == 1) begin
            issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
            issue(flash_wp_pkg::OP_FUNC_WRITE, 1'b0, 1'b0, 12'h000, 8'h02);
            chk(func_q[1], 16'h0001);
         end
         for (int lk = 0; lk < 2; lk++) begin
            layout_1k = lk[0];
            tot = (lk == 1) ? 1024 : 4096;
            for (int c = 0; c < 16; c++) begin
               n = prot_count(c, lk[0]);
               set_sr(8'(c << 2));
               chk(status_q[5:2], 16'(c));
               // top counts down from the last block, bottom up from block zero
               in_blk  = (tb == 1) ? n - 1 : tot - n;
               out_blk = (tb == 1) ? n : tot - n - 1;
               if (n > 0) begin
                  issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
                  issue(8'h02, 1'b1, 1'b0, 12'(in_blk), 8'h00);
                  chk(v, 16'h0004);
               end
               if (n < tot) begin
                  issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
                  issue(8'h02, 1'b1, 1'b0, 12'(out_blk), 8'h00);
                  chk(v, 16'h000A);
                  finish_op();
               end
               issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
               issue((lk == 1) ? flash_wp_pkg::OP_CHIP_ERASE_B : flash_wp_pkg::OP_CHIP_ERASE_A,
                     1'b0, 1'b0, 12'h000, 8'h00);
               chk(v, (c == 0) ? 16'h0009 : 16'h0004);
               if (c == 0) finish_op();
            end
         end
      end
      set_sr(8'h00);
      for (int k = 0; k < 2; k++) begin
         issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
         issue((k == 1) ? 8'h20 : 8'h02, k == 0, k == 1, 12'h005, 8'h00);
         issue(flash_wp_pkg::OP_SUSPEND, 1'b0, 1'b0, 12'h000, 8'h00);
         chk(func_q[3:2], (k == 1) ? 16'h0002 : 16'h0001);
         issue(flash_wp_pkg::OP_RESUME, 1'b0, 1'b0, 12'h000, 8'h00);
         chk(func_q[3:2], 16'h0000);
         finish_op();
      end
      issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
      issue(flash_wp_pkg::OP_FUNC_WRITE, 1'b0, 1'b0, 12'h000, 8'h10);
      issue(flash_wp_pkg::OP_WRITE_ENABLE, 1'b0, 1'b0, 12'h000, 8'h00);
      issue(flash_wp_pkg::OP_FUNC_WRITE, 1'b0, 1'b0, 12'h000, 8'h00);
      chk(func_q, 16'h0013);
      set_sr(8'h80);
      wp_pin_b = 1'b0;
      set_sr(8'h40);
      chk(v, 16'h0004);
      chk(status_q[7:2], 16'h0020);
      wp_pin_b = 1'b1;
      // pins are driven by the bench, not strapped, so quad mode is safe here
      set_sr(8'h40);
      chk(v, 16'h0008);
      chk(status_q[7:2], 16'h0010);
      repeat (2) @(negedge clk);
      chk({quad_lines_q, wp_active_q, hold_active_b_q}, 16'h0005);
      test_done();
   end
endmodule
